// ===== siu_eff_addr.sv
// effective address adder with alignment check
`timescale 1ns/1ns
`default_nettype none
module siu_eff_addr (
  input  wire logic [siu_pkg::XLEN-1:0]  i_base,
  input  wire logic [siu_pkg::IMM_W-1:0] i_imm,
  input  wire logic [2:0]                i_align_mask,
  output logic      [siu_pkg::XLEN-1:0]  o_vaddr,
  output logic                           o_misaligned
);
  import siu_pkg::*;

  // base plus sign-extended offset; carry out of bit 63 wraps by design
  assign o_vaddr      = i_base + siu_sext16(i_imm);
  // a zero mask turns the check off for the unaligned left store
  assign o_misaligned = |(o_vaddr[2:0] & i_align_mask);
endmodule
`default_nettype wire

// ===== siu_left_lane.sv
// byte steering for the left unaligned doubleword store
`timescale 1ns/1ns
`default_nettype none
module siu_left_lane (
  input  wire logic [2:0]               i_vaddr_lo,
  input  wire logic                     i_big_endian,
  input  wire logic [siu_pkg::XLEN-1:0] i_rt_data,
  output logic      [siu_pkg::XLEN-1:0] o_data,
  output logic      [7:0]               o_ben
);
  import siu_pkg::*;

  logic [2:0] byte_sel;

  // lane of the addressed byte, mirrored for a big-endian core
  assign byte_sel = i_vaddr_lo ^ {3{i_big_endian}};

  // top byte of the register lands on the addressed lane, lower ones follow down
  always_comb begin
    o_data = i_rt_data >> (7'd56 - {1'b0, byte_sel, 3'b000});
    o_ben  = 8'hff >> (3'd7 - byte_sel);
  end
endmodule
`default_nettype wire

// ===== siu_mem_model.sv
// memory system and coprocessor units seen from the far side of the store unit
`timescale 1ns/1ns
`default_nettype none
module siu_mem_model (
  input  wire siu_pkg::siu_mem_req_t i_mem,
  input  wire logic                  i_clk,
  input  wire logic [31:0]           i_instr,
  output logic      [63:0]           o_cop_data
);
  import siu_pkg::*;
  logic [63:0] mem [logic [63:0]];
  logic [63:0] churn = 64'h0123_4567_89ab_cdef;

  // unwritten doublewords read back as an address pattern, so zero never passes by luck
  function automatic logic [63:0] peek(input logic [63:0] a);
    return mem.exists(a) ? mem[a] : (~a ^ 64'h5a5a_5a5a_5a5a_5a5a);
  endfunction

  // byte lanes without an enable keep their old contents
  always @(posedge i_clk) begin
    logic [63:0] w;
    churn <= churn + 64'h9e37_79b9_7f4a_7c15;
    if (i_mem.valid === 1'b1) begin
      w = peek(i_mem.addr);
      for (int k = 0; k < 8; k++) begin
        if (i_mem.ben[k]) w[8*k +: 8] = i_mem.data[8*k +: 8];
      end
      mem[i_mem.addr] = w;
    end
  end

  // an unselected unit does not hold its last value: the bus churns every cycle
  always_comb begin
    case (i_instr[31:26])
      OP_COP1_STORE_DWORD: o_cop_data = 64'hc1c1_0123_4567_89ab;
      OP_COP2_STORE_DWORD: o_cop_data = 64'hc2c2_fedc_ba98_7654;
      default:             o_cop_data = churn;
    endcase
  end
endmodule
`default_nettype wire

// ===== siu_pkg.sv
// constants, types and helpers shared by the store instruction unit
// Overview of operation
// - an exception beats a conditional store failure; no failure result is written
// - word conditional store writes memory only while the link bit is set
// - conditional store writes one on success, zero on failure, upper bits cleared
// - doubleword conditional store fails without writing after exception return
// - conditional stores run in user mode without the system control coprocessor
// - doubleword conditional store: address error if low three address bits nonzero
// - effective address is base register plus sign-extended 16-bit offset
// - doubleword store writes all 64 register bits as one doubleword access
// - doubleword store: address error if low three address bits nonzero
// - doubleword stores raise reserved instruction in 32-bit user or supervisor
// - debug break: opcode 000000, function 001110, 20-bit code, raises debug break
// - coprocessor doubleword store writes the unit's doubleword at the address
// - coprocessor doubleword store: address error if low three bits nonzero
// - left store writes the register's left part, other bytes unchanged
// - left store copies from the top byte down to the unit's lowest byte
// - left store never raises an alignment address error
// - word conditional store fails without writing after exception return
// - word conditional store: address error if low two address bits nonzero
package siu_pkg;
  localparam int XLEN      = 64;
  localparam int OPC_LSB   = 26;
  localparam int BASE_LSB  = 21;
  localparam int RT_LSB    = 16;
  localparam int IMM_W     = 16;
  localparam int COP_NUM   = 4;
  localparam logic [5:0] OP_SPECIAL           = 6'h00;
  localparam logic [5:0] FN_DEBUG_BREAK       = 6'h0e;
  localparam logic [5:0] OP_COND_STORE_WORD   = 6'h38;
  localparam logic [5:0] OP_COND_STORE_DWORD  = 6'h3c;
  localparam logic [5:0] OP_COP1_STORE_DWORD  = 6'h3d;
  localparam logic [5:0] OP_COP2_STORE_DWORD  = 6'h3e;
  localparam logic [5:0] OP_STORE_DWORD       = 6'h3f;
  localparam logic [5:0] OP_STORE_DWORD_LEFT  = 6'h2c;
  localparam logic [5:0] OP_STORE_DWORD_RIGHT = 6'h2d;
  localparam logic [2:0] ALIGN_WORD  = 3'h3;
  localparam logic [2:0] ALIGN_DWORD = 3'h7;
  localparam logic [2:0] ALIGN_NONE  = 3'h0;
  localparam logic       LINK_RST    = 1'b0;

  typedef enum logic [2:0] {
    EXC_NONE, EXC_ADDR_ERR, EXC_RESV_INSTR, EXC_COP_UNUSABLE, EXC_DEBUG_BREAK
  } siu_exc_code_t;

  typedef enum logic [2:0] {
    K_NONE, K_CSW, K_CSD, K_SD, K_CPSD, K_SDL, K_SDR, K_DBG
  } siu_kind_t;

  typedef struct packed {
    logic             valid;
    logic [XLEN-1:0]  addr;
    logic [XLEN-1:0]  data;
    logic [7:0]       ben;
  } siu_mem_req_t;

  typedef struct packed {
    logic             valid;
    logic [4:0]       idx;
    logic [XLEN-1:0]  value;
  } siu_wb_t;

  typedef struct packed {
    logic             valid;
    siu_exc_code_t    code;
    logic [XLEN-1:0]  bad_vaddr;
  } siu_exc_t;

  // sign extension of the 16-bit offset to the full address width
  function automatic logic [XLEN-1:0] siu_sext16(input logic [IMM_W-1:0] imm);
    siu_sext16 = {{(XLEN-IMM_W){imm[IMM_W-1]}}, imm};
  endfunction
endpackage

// ===== siu_store_unit.sv
// store instruction unit: decode, address, checks, memory write and result
`timescale 1ns/1ns
`default_nettype none
module siu_store_unit (
  input  wire logic                           i_clk,
  input  wire logic                           i_rstn,
  input  wire logic                           i_valid,
  input  wire logic [31:0]                    i_instr,
  input  wire logic [siu_pkg::XLEN-1:0]       i_base,
  input  wire logic [siu_pkg::XLEN-1:0]       i_rt_data,
  input  wire logic [siu_pkg::XLEN-1:0]       i_cop_data,
  input  wire logic [siu_pkg::COP_NUM-1:0]    i_cop_usable,
  input  wire logic                           i_mode32_usr_sup,
  input  wire logic                           i_big_endian,
  input  wire logic                           i_ll_exec,
  input  wire logic                           i_exception_return_instr_exec,
  output siu_pkg::siu_mem_req_t               o_mem,
  output siu_pkg::siu_wb_t                    o_wb,
  output siu_pkg::siu_exc_t                   o_exc,
  output logic                                o_link
);
  import siu_pkg::*;

  logic [5:0]      opc;
  logic [4:0]      rt_idx;
  logic [1:0]      cop_sel;
  siu_kind_t       kind;
  logic [2:0]      align_mask;
  logic [XLEN-1:0] vaddr;
  logic            misaligned;
  logic [XLEN-1:0] left_data;
  logic [7:0]      left_ben;
  logic            needs_64;
  logic            is_cond;
  siu_exc_code_t   next_code;
  logic            next_store;
  logic [XLEN-1:0] next_data;
  logic [7:0]      next_ben;
  logic            word_lane;

  assign opc     = i_instr[31:OPC_LSB];
  assign rt_idx  = i_instr[RT_LSB+4:RT_LSB];
  assign cop_sel = opc[1:0];

  // instruction decode; the code field of the debug break is not carried on
  always_comb begin
    kind = K_NONE;
    case (opc)
      OP_SPECIAL: begin
        if (i_instr[5:0] == FN_DEBUG_BREAK) begin
          kind = K_DBG;
        end
      end
      OP_COND_STORE_WORD:   kind = K_CSW;
      OP_COND_STORE_DWORD:  kind = K_CSD;
      OP_STORE_DWORD:       kind = K_SD;
      OP_COP1_STORE_DWORD:  kind = K_CPSD;
      OP_COP2_STORE_DWORD:  kind = K_CPSD;
      OP_STORE_DWORD_LEFT:  kind = K_SDL;
      OP_STORE_DWORD_RIGHT: kind = K_SDR;
      default:              kind = K_NONE;
    endcase
  end

  // alignment demanded by each store
  always_comb begin
    case (kind)
      K_CSW:   align_mask = ALIGN_WORD;
      K_CSD:   align_mask = ALIGN_DWORD;
      K_SD:    align_mask = ALIGN_DWORD;
      K_CPSD:  align_mask = ALIGN_DWORD;
      K_SDL:   align_mask = ALIGN_NONE;
      default: align_mask = ALIGN_NONE;
    endcase
  end

  siu_eff_addr u_eff_addr (
    .i_base       (i_base),
    .i_imm        (i_instr[IMM_W-1:0]),
    .i_align_mask (align_mask),
    .o_vaddr      (vaddr),
    .o_misaligned (misaligned)
  );

  siu_left_lane u_left_lane (
    .i_vaddr_lo   (vaddr[2:0]),
    .i_big_endian (i_big_endian),
    .i_rt_data    (i_rt_data),
    .o_data       (left_data),
    .o_ben        (left_ben)
  );

  // doubleword stores other than the coprocessor one, including the right part store, are 64-bit only
  assign needs_64 = (kind == K_CSD) || (kind == K_SD) || (kind == K_SDL) || (kind == K_SDR);
  assign is_cond  = (kind == K_CSW) || (kind == K_CSD);

  // exception priority: reserved, coprocessor unusable, alignment, debug break
  // conditional stores never look at coprocessor usability, so user mode works
  always_comb begin
    next_code = EXC_NONE;
    if (needs_64 && i_mode32_usr_sup) begin
      next_code = EXC_RESV_INSTR;
    end else if ((kind == K_CPSD) && !i_cop_usable[cop_sel]) begin
      next_code = EXC_COP_UNUSABLE;
    end else if (misaligned) begin
      next_code = EXC_ADDR_ERR;
    end else if (kind == K_DBG) begin
      next_code = EXC_DEBUG_BREAK;
    end
  end

  // word lane inside the doubleword; big-endian flips the half
  assign word_lane = vaddr[2] ^ i_big_endian;

  // write enable and byte steering per store kind
  // the right part store only checks its mode here; it never writes memory
  always_comb begin
    next_store = 1'b0;
    next_data  = i_rt_data;
    next_ben   = 8'hff;
    if (i_valid && (next_code == EXC_NONE)) begin
      case (kind)
        K_CSW: begin
          next_store = o_link;
          next_data  = {2{i_rt_data[31:0]}};
          next_ben   = word_lane ? 8'hf0 : 8'h0f;
        end
        K_CSD: begin
          next_store = o_link;
        end
        K_SD: begin
          next_store = 1'b1;
        end
        K_CPSD: begin
          next_store = 1'b1;
          next_data  = i_cop_data;
        end
        K_SDL: begin
          next_store = 1'b1;
          next_data  = left_data;
          next_ben   = left_ben;
        end
        default: next_store = 1'b0;
      endcase
    end
  end

  // link bit: a load-linked in the same cycle as a return wins over the clear
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_link <= LINK_RST;
    end else if (i_ll_exec) begin
      o_link <= 1'b1;
    end else if (i_exception_return_instr_exec) begin
      o_link <= 1'b0;
    end
  end

  // memory write request, one cycle after the instruction is taken
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_mem <= '0;
    end else begin
      o_mem.valid <= next_store;
      o_mem.addr  <= {vaddr[XLEN-1:3], 3'b000};
      o_mem.data  <= next_data;
      o_mem.ben   <= next_ben;
    end
  end

  // success or failure result back to the source register; suppressed under an exception
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_wb <= '0;
    end else begin
      o_wb.valid <= i_valid && is_cond && (next_code == EXC_NONE);
      o_wb.idx   <= rt_idx;
      o_wb.value <= {{(XLEN-1){1'b0}}, o_link};
    end
  end

  // exception report with the faulting address for the handler
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_exc <= '{valid: 1'b0, code: EXC_NONE, bad_vaddr: '0};
    end else begin
      o_exc.valid     <= i_valid && (next_code != EXC_NONE);
      o_exc.code      <= i_valid ? next_code : EXC_NONE;
      o_exc.bad_vaddr <= vaddr;
    end
  end

  // checks on the outputs against the request that caused them
  sequence s_csw_unlinked;
    i_valid && (kind == K_CSW) && !o_link && !misaligned;
  endsequence

  sequence s_dw_misaligned;
    i_valid && !i_mode32_usr_sup && ((kind == K_CSD) || (kind == K_SD)) && (vaddr[2:0] != 3'h0);
  endsequence

  sequence s_sd_clean;
    i_valid && (kind == K_SD) && !i_mode32_usr_sup && (vaddr[2:0] == 3'h0);
  endsequence

  sequence s_csd_unlinked;
    i_valid && (kind == K_CSD) && !i_mode32_usr_sup && !o_link && !misaligned;
  endsequence

  sequence s_cop_ready;
    i_valid && (kind == K_CPSD) && i_cop_usable[cop_sel];
  endsequence

  property p_exc_blocks_all;
    @(posedge i_clk) disable iff (!i_rstn)
      o_exc.valid |-> !o_mem.valid && !o_wb.valid;
  endproperty
  a_exc_blocks_all: assert property (p_exc_blocks_all) else $error("write with exception");

  property p_csw_needs_link;
    @(posedge i_clk) disable iff (!i_rstn)
      s_csw_unlinked |=> !o_mem.valid && o_wb.valid && (o_wb.value == 64'h0);
  endproperty
  a_csw_needs_link: assert property (p_csw_needs_link) else $error("unlinked store wrote");

  property p_result_value;
    @(posedge i_clk) disable iff (!i_rstn)
      o_wb.valid |-> (o_wb.value[63:1] == 63'h0) && (o_wb.value[0] == o_mem.valid);
  endproperty
  a_result_value: assert property (p_result_value) else $error("bad result value");

  property p_dw_align;
    @(posedge i_clk) disable iff (!i_rstn)
      s_dw_misaligned |=> o_exc.valid && (o_exc.code == EXC_ADDR_ERR);
  endproperty
  a_dw_align: assert property (p_dw_align) else $error("missing address error");

  property p_addr_from_offset;
    @(posedge i_clk) disable iff (!i_rstn)
      i_valid ##1 o_mem.valid |->
        o_mem.addr[63:3] == ($past(i_base) + siu_sext16($past(i_instr[15:0]))) >> 3;
  endproperty
  a_addr_from_offset: assert property (p_addr_from_offset) else $error("bad address");

  property p_sd_full;
    @(posedge i_clk) disable iff (!i_rstn)
      s_sd_clean |=> o_mem.valid && (o_mem.ben == 8'hff) && (o_mem.data == $past(i_rt_data));
  endproperty
  a_sd_full: assert property (p_sd_full) else $error("doubleword store incomplete");

  property p_mode32_reserved;
    @(posedge i_clk) disable iff (!i_rstn)
      i_valid && needs_64 && i_mode32_usr_sup |=> o_exc.code == EXC_RESV_INSTR;
  endproperty
  a_mode32_reserved: assert property (p_mode32_reserved) else $error("no reserved exc");

  property p_debug_break;
    @(posedge i_clk) disable iff (!i_rstn)
      i_valid && (i_instr[31:26] == 6'h00) && (i_instr[5:0] == 6'h0e)
        |=> o_exc.valid && (o_exc.code == EXC_DEBUG_BREAK);
  endproperty
  a_debug_break: assert property (p_debug_break) else $error("no debug break");

  property p_left_no_align;
    @(posedge i_clk) disable iff (!i_rstn)
      i_valid && (kind == K_SDL) && !i_mode32_usr_sup
        |=> !o_exc.valid && o_mem.valid && o_mem.ben[0];
  endproperty
  a_left_no_align: assert property (p_left_no_align) else $error("left store faulted");

  property p_link_track;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_ll_exec |=> o_link) and (i_exception_return_instr_exec && !i_ll_exec |=> !o_link);
  endproperty
  a_link_track: assert property (p_link_track) else $error("link bit wrong");

  property p_csd_needs_link;
    @(posedge i_clk) disable iff (!i_rstn)
      s_csd_unlinked |=> !o_mem.valid && o_wb.valid && (o_wb.value == 64'h0);
  endproperty
  a_csd_needs_link: assert property (p_csd_needs_link) else $error("dword wrote");

  // the word store must not depend on coprocessor usability in any mode
  property p_csw_user_mode;
    @(posedge i_clk) disable iff (!i_rstn)
      i_valid && (kind == K_CSW) && !misaligned |=> !o_exc.valid && o_wb.valid;
  endproperty
  a_csw_user_mode: assert property (p_csw_user_mode) else $error("cond store trapped");

  property p_word_align;
    @(posedge i_clk) disable iff (!i_rstn)
      i_valid && (kind == K_CSW) && (vaddr[1:0] != 2'h0)
        |=> o_exc.valid && (o_exc.code == EXC_ADDR_ERR) && !o_wb.valid;
  endproperty
  a_word_align: assert property (p_word_align) else $error("word store misaligned");

  property p_cop_align;
    @(posedge i_clk) disable iff (!i_rstn)
      s_cop_ready ##0 (vaddr[2:0] != 3'h0)
        |=> o_exc.valid && (o_exc.code == EXC_ADDR_ERR) && !o_mem.valid;
  endproperty
  a_cop_align: assert property (p_cop_align) else $error("cop store misaligned");

  property p_cop_data;
    @(posedge i_clk) disable iff (!i_rstn)
      s_cop_ready ##0 (vaddr[2:0] == 3'h0)
        |=> o_mem.valid && (o_mem.ben == 8'hff) && (o_mem.data == $past(i_cop_data));
  endproperty
  a_cop_data: assert property (p_cop_data) else $error("coprocessor data lost");
endmodule
`default_nettype wire

// ===== testbench.sv
// self-checking testbench for the store instruction unit
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import siu_pkg::*;
  logic         i_clk = 1'b0;
  logic         i_rstn = 1'b0;
  logic         i_valid = 1'b0;
  logic [31:0]  i_instr = 32'h0;
  logic [63:0]  i_base = 64'h0;
  logic [63:0]  i_rt_data = 64'h0;
  logic [63:0]  i_cop_data;
  logic [3:0]   i_cop_usable = 4'h0;
  logic         i_mode32_usr_sup = 1'b0;
  logic         i_big_endian = 1'b0;
  logic         i_ll_exec = 1'b0;
  logic         i_exception_return_instr_exec = 1'b0;
  siu_mem_req_t mem;
  siu_wb_t      wb;
  siu_exc_t     exc;
  logic         link;
  int           fail_count = 0;
  int           n_compared = 0;
  localparam logic [63:0] RT = 64'hdead_beef_0bad_cafe;

  always #2 i_clk = ~i_clk;

  siu_store_unit dut_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_valid(i_valid), .i_instr(i_instr),
    .i_base(i_base), .i_rt_data(i_rt_data), .i_cop_data(i_cop_data),
    .i_cop_usable(i_cop_usable), .i_mode32_usr_sup(i_mode32_usr_sup),
    .i_big_endian(i_big_endian), .i_ll_exec(i_ll_exec), .i_exception_return_instr_exec(i_exception_return_instr_exec),
    .o_mem(mem), .o_wb(wb), .o_exc(exc), .o_link(link));
  siu_mem_model mem_u (.i_mem(mem), .i_clk(i_clk), .i_instr(i_instr), .o_cop_data(i_cop_data));

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // one instruction for one cycle; outputs are looked at in their single answer cycle
  task automatic issue(input logic [5:0] op, input logic [63:0] base, input logic [15:0] imm);
    @(posedge i_clk);
    #1;
    i_valid = 1'b1;
    // rt field kept even and no scenario names coprocessor zero
    i_instr = {op, 5'd3, 5'd8, imm};
    i_base = base;
    i_rt_data = RT;
    @(posedge i_clk);
    #1;
    i_valid = 1'b0;
  endtask

  task automatic link_pulse(input logic ll, input logic er);
    @(posedge i_clk);
    #1;
    i_ll_exec = ll;
    i_exception_return_instr_exec = er;
    @(posedge i_clk);
    #1;
    i_ll_exec = 1'b0;
    i_exception_return_instr_exec = 1'b0;
  endtask

  // memory write, result and exception seen in the answer cycle
  task automatic outcome(input logic mv, input logic wv, input logic [63:0] wval,
                         input logic ev, input logic [2:0] code);
    chk(mem.valid, mv);
    chk(wb.valid, wv);
    if (wv) chk(wb.value, wval);
    if (wv) chk(wb.idx, 5'd8);
    chk(exc.valid, ev);
    if (ev) chk(exc.code, code);
  endtask

  task automatic t_cond_word();
    i_mode32_usr_sup = 1'b1;  // user mode with no coprocessor usable
    i_cop_usable = 4'h0;
    link_pulse(1'b1, 1'b0);
    chk(link, 1'b1);
    issue(OP_COND_STORE_WORD, 64'h1000, 16'h0014);
    outcome(1, 1, 64'h1, 0, 0);
    chk(mem.addr, 64'h1010);
    chk(mem.data, {2{32'h0bad_cafe}});
    chk(mem.ben, 8'hf0);
    i_big_endian = 1'b1;
    issue(OP_COND_STORE_WORD, 64'h1000, 16'h0014);
    chk(mem.ben, 8'h0f);
    i_big_endian = 1'b0;
    issue(OP_COND_STORE_WORD, 64'h1000, 16'h0016);
    outcome(0, 0, 0, 1, EXC_ADDR_ERR);
    chk(exc.bad_vaddr, 64'h1016);
    link_pulse(1'b0, 1'b1);
    chk(link, 1'b0);
    issue(OP_COND_STORE_WORD, 64'h1000, 16'h0014);
    outcome(0, 1, 64'h0, 0, 0);
    issue(OP_COND_STORE_WORD, 64'h1000, 16'h0011);
    outcome(0, 0, 0, 1, EXC_ADDR_ERR);
    $display("test cond_word done");
  endtask

  task automatic t_cond_dword();
    i_mode32_usr_sup = 1'b0;
    link_pulse(1'b1, 1'b1);
    chk(link, 1'b1);
    link_pulse(1'b1, 1'b0);
    // every doubleword conditional store uses base 0x2000 with a negative offset
    issue(OP_COND_STORE_DWORD, 64'h2000, 16'hfff8);
    outcome(1, 1, 64'h1, 0, 0);
    chk(mem.addr, 64'h1ff8);
    chk(mem.data, RT);
    issue(OP_COND_STORE_DWORD, 64'h2000, 16'hfffc);
    outcome(0, 0, 0, 1, EXC_ADDR_ERR);
    i_mode32_usr_sup = 1'b1;
    issue(OP_COND_STORE_DWORD, 64'h2000, 16'hfff8);
    outcome(0, 0, 0, 1, EXC_RESV_INSTR);
    i_mode32_usr_sup = 1'b0;
    link_pulse(1'b0, 1'b1);
    issue(OP_COND_STORE_DWORD, 64'h2000, 16'hfff8);
    outcome(0, 1, 64'h0, 0, 0);
    issue(OP_COND_STORE_DWORD, 64'h2000, 16'hfff9);
    outcome(0, 0, 0, 1, EXC_ADDR_ERR);
    $display("test cond_dword done");
  endtask

  task automatic t_store_dword();
    logic [5:0] ops [3] = '{OP_STORE_DWORD, OP_STORE_DWORD_LEFT, OP_STORE_DWORD_RIGHT};
    for (int k = 1; k < 8; k++) begin
      issue(OP_STORE_DWORD, 64'h3000, k[15:0]);
      outcome(0, 0, 0, 1, EXC_ADDR_ERR);
      chk(exc.bad_vaddr, 64'h3000 + k);
    end
    issue(OP_STORE_DWORD, 64'h3000, 16'h8008);
    outcome(1, 0, 0, 0, 0);
    chk(mem.addr, 64'hffff_ffff_ffff_b008);
    chk({mem.data, mem.ben}, {RT, 8'hff});
    i_mode32_usr_sup = 1'b1;
    for (int k = 0; k < 3; k++) begin
      issue(ops[k], 64'h3000, 16'h0008);
      outcome(0, 0, 0, 1, EXC_RESV_INSTR);
    end
    i_mode32_usr_sup = 1'b0;
    // outside the 32-bit modes the right part store raises nothing here
    issue(OP_STORE_DWORD_RIGHT, 64'h3000, 16'h0008);
    outcome(0, 0, 0, 0, 0);
    $display("test store_dword done");
  endtask

  task automatic t_coproc_debug();
    i_cop_usable = 4'h6;
    issue(OP_COP1_STORE_DWORD, 64'h4000, 16'h0010);
    outcome(1, 0, 0, 0, 0);
    chk({mem.addr, mem.data}, {64'h4010, 64'hc1c1_0123_4567_89ab});
    issue(OP_COP2_STORE_DWORD, 64'h4000, 16'h0018);
    chk({mem.valid, mem.data}, {1'b1, 64'hc2c2_fedc_ba98_7654});
    issue(OP_COP1_STORE_DWORD, 64'h4000, 16'h0012);
    outcome(0, 0, 0, 1, EXC_ADDR_ERR);
    i_cop_usable = 4'h4;  // unit one unusable: no write may reach memory
    issue(OP_COP1_STORE_DWORD, 64'h4000, 16'h0010);
    outcome(0, 0, 0, 1, EXC_COP_UNUSABLE);
    issue(OP_SPECIAL, 64'h4000, 16'h3a8e);
    outcome(0, 0, 0, 1, EXC_DEBUG_BREAK);
    issue(OP_SPECIAL, 64'h4000, 16'h3a8f);
    outcome(0, 0, 0, 0, 0);
    $display("test coproc_debug done");
  endtask

  // every byte offset in both byte orders, then the memory merge is read back
  task automatic t_left();
    int          b;
    logic [63:0] old;
    logic [63:0] exp;
    for (int e = 0; e < 2; e++) begin
      for (int v = 0; v < 8; v++) begin
        i_big_endian = e[0];
        b = v ^ (e * 7);
        old = mem_u.peek(64'h5000);
        issue(OP_STORE_DWORD_LEFT, 64'h5000, v[15:0]);
        outcome(1, 0, 0, 0, 0);
        chk(mem.data, RT >> (56 - 8 * b));
        chk(mem.ben, 8'hff >> (7 - b));
        exp = old;
        for (int k = 0; k <= b; k++) exp[8*k +: 8] = RT[8*(k+7-b) +: 8];
        @(posedge i_clk);
        #1;
        chk(mem_u.peek(64'h5000), exp);
      end
    end
    i_big_endian = 1'b0;
    $display("test left done");
  endtask

  initial begin
    repeat (5) @(posedge i_clk);
    #1;
    i_rstn = 1'b1;
    chk({mem.valid, wb.valid, exc.valid, link}, 4'h0);
    t_cond_word();
    t_cond_dword();
    t_store_dword();
    t_coproc_debug();
    t_left();
    conclude();
  end

  // hang guard: counts as a mismatch and closes the run
  initial begin
    #100000;
    chk(1'b0, 1'b1);
    conclude();
  end
endmodule
`default_nettype wire
